// ### lcs_map.svh
/*
  Constants for the segment LCD common sequencer: level codes, mode codes,
  display geometry and the LCD clock tick period.
  Assumes it is included by bare name by the design module, the glass model and the bench.
*/
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH

`define LCS_NUM_SEG 40
`define LCS_NUM_COM 4
`define LCS_SEG_ADDR_FIRST 6'h00
`define LCS_SEG_ADDR_LAST 6'h27
`define LCS_LVL_GROUND 2'h0
`define LCS_LVL_LOWER 2'h1
`define LCS_LVL_UPPER 2'h2
`define LCS_LVL_TOP 2'h3
`define LCS_SLOTS_STATIC 2'h0
`define LCS_SLOTS_TWO 2'h1
`define LCS_SLOTS_THREE 2'h2
`define LCS_SLOTS_FOUR 2'h3
`define LCS_BIAS_NONE 2'h0
`define LCS_BIAS_HALF 2'h1
`define LCS_BIAS_THIRD 2'h2
`define LCS_FRAME_SLOTS_FOUR 3'h4
`define LCS_LCD_CLK_NS 1000
`define LCS_CLK_NS 8
`define LCS_TICK_CYCLES ((`LCS_LCD_CLK_NS) / (`LCS_CLK_NS))

`endif

// ### lcs_pkg.sv
/*
  Types for the segment LCD common sequencer.
  Assumes lcs_map.svh is on the include path.
*/
package lcs_pkg;
  typedef logic [1:0] lcs_level_t;

  typedef enum logic [1:0] {
    LCS_STATIC = 2'h0,
    LCS_TWO = 2'h1,
    LCS_THREE = 2'h2,
    LCS_FOUR = 2'h3
  } lcs_slots_e;

  typedef enum logic [1:0] {
    LCS_NO_BIAS = 2'h0,
    LCS_HALF_BIAS = 2'h1,
    LCS_THIRD_BIAS = 2'h2,
    LCS_BIAS_RSVD = 2'h3
  } lcs_bias_e;

  typedef struct packed {
    lcs_slots_e slots;
    lcs_bias_e bias;
  } lcs_cfg_s;

  // Slot walk, Gray coded along the usual path
  typedef enum logic [1:0] {
    LCS_SLOT0 = 2'b00,
    LCS_SLOT1 = 2'b01,
    LCS_SLOT2 = 2'b11,
    LCS_SLOT3 = 2'b10
  } lcs_slot_e;

  typedef struct packed {
    lcs_level_t [3:0] com;
    lcs_level_t [39:0] seg;
  } lcs_drive_s;
endpackage

// ### lcs_sequencer.sv
/*
  Segment LCD common/segment drive sequencer. Emits a two-bit level select
  per common and segment pin to an external analog switch array.
  Assumes display memory is written by a separate port on this clock, and
  that configuration is quasi-static; lcd_tick width from the tick counter.
*/
`timescale 1ns/1ps
`include "lcs_map.svh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// - Half bias: common top/ground, idle mid
// - Third bias: idle levels alternate, segments swing
// - Four-slot frame lasts four LCD clocks
// - Static mode: all commons identical
// - Polarity reverses every frame
// - Bit k selects during common k slot
// - Static mode uses only bit 0
// - Two-slot mode ignores bits 2, 3
// - Three-slot mode ignores bit 3
// - Bytes 00H-27H map to segments 0-39
// - One is select, zero deselect
// - Commons activate in ascending order, repeat
module lcs_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Configuration
  input wire lcs_pkg::lcs_cfg_s cfg,
  // Display memory write port
  input wire logic mem_we,
  input wire logic [5:0] mem_addr,
  input wire logic [3:0] mem_wdata,
  // Drive outputs
  output lcs_pkg::lcs_drive_s drive,
  output logic frame_start
);

  localparam int TICK_CYCLES = (`LCS_TICK_CYCLES < 1) ? 1 : `LCS_TICK_CYCLES;

  // Only the low nibble is stored; high bits have no storage
  logic [3:0] mem_r [`LCS_NUM_SEG];
  logic [3:0] mem_nxt [`LCS_NUM_SEG];
  logic [15:0] tick_cnt_r, tick_cnt_nxt;
  lcs_pkg::lcs_slot_e slot_r, slot_nxt;
  logic phase_r, phase_nxt;
  lcs_pkg::lcs_cfg_s cfg_r, cfg_nxt;
  lcs_pkg::lcs_drive_s drive_nxt;
  logic frame_start_nxt;
  logic tick;
  logic [1:0] slot_idx;
  logic [1:0] last_idx;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < `LCS_NUM_SEG; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    // Byte offset i drives segment pin i
    if (mem_we && mem_addr <= `LCS_SEG_ADDR_LAST) begin
      mem_nxt[mem_addr] = mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    unique case (slot_r)
      lcs_pkg::LCS_SLOT0: slot_idx = 2'h0;
      lcs_pkg::LCS_SLOT1: slot_idx = 2'h1;
      lcs_pkg::LCS_SLOT2: slot_idx = 2'h2;
      lcs_pkg::LCS_SLOT3: slot_idx = 2'h3;
    endcase
    // Static counts as one slot, so last index equals mode code
    last_idx = cfg.slots;
  end

  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  always_comb begin
    cfg_nxt = cfg;
    tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    slot_nxt = slot_r;
    phase_nxt = phase_r;
    frame_start_nxt = 1'b0;
    if (cfg != cfg_r) begin
      // Restart cleanly so a half-built frame never puts DC on glass
      tick_cnt_nxt = 16'h0000;
      slot_nxt = lcs_pkg::LCS_SLOT0;
      phase_nxt = 1'b0;
      frame_start_nxt = 1'b1;
    end else if (tick) begin
      // Ascending commons, wrap at slot count
      if (slot_idx >= last_idx) begin
        slot_nxt = lcs_pkg::LCS_SLOT0;
        phase_nxt = ~phase_r;
        frame_start_nxt = 1'b1;
      end else begin
        unique case (slot_r)
          lcs_pkg::LCS_SLOT0: slot_nxt = lcs_pkg::LCS_SLOT1;
          lcs_pkg::LCS_SLOT1: slot_nxt = lcs_pkg::LCS_SLOT2;
          lcs_pkg::LCS_SLOT2: slot_nxt = lcs_pkg::LCS_SLOT3;
          lcs_pkg::LCS_SLOT3: slot_nxt = lcs_pkg::LCS_SLOT0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level encoding
  always_comb begin
    logic com_act;
    logic seg_sel;
    logic [3:0] nib;
    com_act = 1'b0;
    seg_sel = 1'b0;
    nib = 4'h0;
    drive_nxt = '0;
    for (int c = 0; c < `LCS_NUM_COM; c++) begin
      // Static: every common active, identical
      com_act = (cfg_r.slots == lcs_pkg::LCS_STATIC) || (2'(c) == slot_idx);
      if (com_act) begin
        drive_nxt.com[c] = phase_r ? `LCS_LVL_GROUND : `LCS_LVL_TOP;
      end else if (cfg_r.bias == lcs_pkg::LCS_THIRD_BIAS) begin
        drive_nxt.com[c] = phase_r ? `LCS_LVL_UPPER : `LCS_LVL_LOWER;
      end else begin
        // Both mid supplies are tied in half bias, lower code used
        drive_nxt.com[c] = `LCS_LVL_LOWER;
      end
    end
    for (int s = 0; s < `LCS_NUM_SEG; s++) begin
      nib = mem_r[s];
      // Slot index never reaches unused bits in shorter modes
      seg_sel = (cfg_r.slots == lcs_pkg::LCS_STATIC) ? nib[0] : nib[slot_idx];
      if (seg_sel || cfg_r.bias != lcs_pkg::LCS_THIRD_BIAS) begin
        // Select opposes the common; deselect follows it
        drive_nxt.seg[s] = (seg_sel ^ phase_r) ? `LCS_LVL_GROUND : `LCS_LVL_TOP;
      end else begin
        drive_nxt.seg[s] = phase_r ? `LCS_LVL_LOWER : `LCS_LVL_UPPER;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `LCS_NUM_SEG; i++) begin
        mem_r[i] <= 4'h0;
      end
      tick_cnt_r <= 16'h0000;
      slot_r <= lcs_pkg::LCS_SLOT0;
      phase_r <= 1'b0;
      cfg_r <= '0;
      drive <= '0;
      frame_start <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      slot_r <= slot_nxt;
      phase_r <= phase_nxt;
      cfg_r <= cfg_nxt;
      drive <= drive_nxt;
      frame_start <= frame_start_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_four_frame;
    @(posedge clock) disable iff (!rst_b)
    (tick && slot_r == lcs_pkg::LCS_SLOT3 && cfg == cfg_r
     && cfg_r.slots == lcs_pkg::LCS_FOUR) |=> slot_r == lcs_pkg::LCS_SLOT0 && frame_start;
  endproperty
  a_four_frame: assert property (p_four_frame) else $error("four slot wrap");

  property p_restart;
    @(posedge clock) disable iff (!rst_b)
    (cfg != cfg_r) |=> slot_r == lcs_pkg::LCS_SLOT0 && tick_cnt_r == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("config restart");

  property p_static_same;
    @(posedge clock) disable iff (!rst_b)
    (cfg_r.slots == lcs_pkg::LCS_STATIC && $stable(cfg_r)) |=>
      drive.com[0] == drive.com[1] && drive.com[0] == drive.com[3]
      && drive.com[1] == drive.com[2];
  endproperty
  a_static_same: assert property (p_static_same) else $error("static commons");

  property p_ascend;
    @(posedge clock) disable iff (!rst_b)
    (tick && cfg == cfg_r && slot_idx < last_idx) |=> slot_idx == $past(slot_idx) + 2'h1;
  endproperty
  a_ascend: assert property (p_ascend) else $error("slot order");

  property p_flip;
    @(posedge clock) disable iff (!rst_b)
    (frame_start && $past(cfg) == $past(cfg_r)) |-> phase_r != $past(phase_r);
  endproperty
  a_flip: assert property (p_flip) else $error("polarity flip");

  property p_half_idle;
    @(posedge clock) disable iff (!rst_b)
    ($stable(cfg_r) && cfg_r.bias == lcs_pkg::LCS_HALF_BIAS && cfg_r.slots == lcs_pkg::LCS_FOUR
     && slot_idx != 2'h0 && $stable(slot_r)) |=> drive.com[0] == `LCS_LVL_LOWER;
  endproperty
  a_half_idle: assert property (p_half_idle) else $error("half bias idle");

  property p_sel_opp;
    @(posedge clock) disable iff (!rst_b)
    (cfg_r.slots == lcs_pkg::LCS_FOUR && mem_r[0][slot_idx] && $stable(slot_r)
     && $stable(cfg_r) && !mem_we) |=> drive.seg[0] == ~drive.com[$past(slot_idx)];
  endproperty
  a_sel_opp: assert property (p_sel_opp) else $error("select opposes common");

  property p_third_seg;
    @(posedge clock) disable iff (!rst_b)
    (cfg_r.bias == lcs_pkg::LCS_THIRD_BIAS && cfg_r.slots == lcs_pkg::LCS_FOUR && !mem_r[1][slot_idx]
     && $stable(cfg_r)) |=> drive.seg[1] inside {`LCS_LVL_LOWER, `LCS_LVL_UPPER};
  endproperty
  a_third_seg: assert property (p_third_seg) else $error("third bias deselect");

  c_four: cover property (@(posedge clock) disable iff (!rst_b)
    cfg_r.slots == lcs_pkg::LCS_FOUR && frame_start);
  c_static: cover property (@(posedge clock) disable iff (!rst_b)
    cfg_r.slots == lcs_pkg::LCS_STATIC && frame_start);
  c_restart: cover property (@(posedge clock) disable iff (!rst_b) cfg != cfg_r);
endmodule

// ### lcs_panel.sv
/*
  Glass model: a pixel is lit when its common and segment sit at opposite rails.
  Assumes the level codes of lcs_map.svh on the drive bus.
*/
`timescale 1ns/1ps
`include "lcs_map.svh"
module lcs_panel (
  // Drive in
  input wire lcs_pkg::lcs_drive_s drive,
  // Lit pixels
  output logic [3:0][39:0] lit
);
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 40; s++) begin
        // Bias steps never light a pixel
        lit[c][s] = ((drive.com[c] ^ drive.seg[s]) == 2'h3) &&
                    (drive.com[c] == `LCS_LVL_TOP || drive.com[c] == `LCS_LVL_GROUND);
      end
    end
  end
endmodule

// ### lcs_sequencer_tb.sv
/*
  Self-checking bench for the sequencer, with the glass model on its outputs.
  Assumes the 125-clock LCD tick of lcs_map.svh.
*/
`timescale 1ns/1ps
`include "lcs_map.svh"
module lcs_sequencer_tb;
  typedef struct packed {lcs_pkg::lcs_cfg_s cfg; logic [3:0] mask;} lcs_row_s;
  logic clock = 0;
  logic rst_b = 0;
  lcs_pkg::lcs_cfg_s cfg = '0;
  logic mem_we = 0;
  logic [5:0] mem_addr = '0;
  logic [3:0] mem_wdata = '0;
  lcs_pkg::lcs_drive_s drive;
  logic frame_start;
  logic [3:0][39:0] lit;
  logic [3:0] mem [40];
  int fail_count = 0;
  int check_count = 0;
  // Last row uses the spare bias code, which must behave as half bias
  lcs_row_s rows [8] = '{8'h0A, 8'h55, 8'h93, 8'hAC, 8'hE6, 8'hC9, 8'h6F, 8'h73};

  always #4 clock = ~clock;

  lcs_sequencer lcs_sequencer_i (.clock(clock), .rst_b(rst_b), .cfg(cfg), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .drive(drive), .frame_start(frame_start));
  lcs_panel lcs_panel_i (.drive(drive), .lit(lit));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(logic ok, string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic wr(logic [5:0] a, logic [3:0] d);
    mem_we <= 1'b1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clock);
    mem_we <= 1'b0;
    @(posedge clock);
  endtask

  // Cycles between two frame pulses, sampled where settled
  task automatic period(int want);
    int t;
    t = 0;
    // Look from the next falling edge on, so a pulse already up is not taken
    do begin
      @(negedge clock);
      t++;
    end while (frame_start !== 1'b1 && t < 2000);
    t = 0;
    do begin
      @(negedge clock);
      t++;
    end while (frame_start !== 1'b1 && t < 2000);
    chk(t == want, "frame length");
  endtask

  function automatic lcs_pkg::lcs_drive_s expd(lcs_pkg::lcs_cfg_s c, int s, logic ph);
    lcs_pkg::lcs_drive_s d;
    logic third;
    third = (c.bias == lcs_pkg::LCS_THIRD_BIAS);
    for (int k = 0; k < 4; k++) begin
      if (c.slots == lcs_pkg::LCS_STATIC || k == s) begin
        d.com[k] = ph ? `LCS_LVL_GROUND : `LCS_LVL_TOP;
      end else begin
        d.com[k] = (third && ph) ? `LCS_LVL_UPPER : `LCS_LVL_LOWER;
      end
    end
    for (int i = 0; i < 40; i++) begin
      if (mem[i][s]) d.seg[i] = ph ? `LCS_LVL_TOP : `LCS_LVL_GROUND;
      else if (third) d.seg[i] = ph ? `LCS_LVL_LOWER : `LCS_LVL_UPPER;
      else d.seg[i] = ph ? `LCS_LVL_GROUND : `LCS_LVL_TOP;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    fail_count++;
    $display("BAD %0t watchdog", $time);
    conclude();
  end

  initial begin
    int n;
    logic [39:0] e;
    repeat (20) @(posedge clock);
    chk(drive === '0 && frame_start === 1'b0, "reset outputs");
    rst_b <= 1'b1;
    @(posedge clock);
    foreach (rows[r]) begin
      // Spare bits carry junk on purpose
      for (int i = 0; i < 40; i++) begin
        mem[i] = i[3:0] ^ rows[r].mask;
        wr(i[5:0], mem[i]);
      end
      wr(6'h28, 4'hF);
      // Detour through another setting so every row starts at slot 0, phase 0
      cfg <= lcs_pkg::lcs_cfg_s'(~rows[r].cfg);
      @(posedge clock);
      cfg <= rows[r].cfg;
      n = (rows[r].cfg.slots == lcs_pkg::LCS_STATIC) ? 1 : int'(rows[r].cfg.slots) + 1;
      // Mid-slot sampling tolerates a few cycles of restart latency
      repeat (60) @(posedge clock);
      for (int j = 0; j < 2 * n; j++) begin
        chk(drive === expd(cfg, j % n, j >= n), "drive levels");
        for (int i = 0; i < 40; i++) e[i] = mem[i][j % n];
        chk(lit[(n == 1) ? 3 : j % n] === e, "lit pixels");
        repeat (125) @(posedge clock);
      end
    end
    cfg <= 4'hD;
    period(4 * `LCS_TICK_CYCLES);
    @(posedge clock);
    cfg <= 4'h0;
    period(`LCS_TICK_CYCLES);
    @(posedge clock);
    mem[5][0] = ~mem[5][0];
    wr(6'h05, mem[5]);
    @(negedge clock);
    chk(drive.seg[5] === (mem[5][0] ? ~drive.com[0] : drive.com[0]), "live write");
    @(posedge clock);
    rst_b <= 1'b0;
    @(negedge clock);
    chk(drive === '0 && frame_start === 1'b0, "second reset");
    @(posedge clock);
    rst_b <= 1'b1;
    repeat (10) @(negedge clock);
    chk(drive.seg === {40{drive.com[0]}}, "memory cleared");
    conclude();
  end
endmodule
